// [rtl/sdtx_pkg.sv]
package sdtx_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register byte offsets
  localparam logic [3:0] SDTX_CTRL_OFS = 4'h0;
  localparam logic [3:0] SDTX_STAT_OFS = 4'h4;
  localparam logic [3:0] SDTX_PINS_OFS = 4'h8;

  // control register fields and reset values
  localparam int SDTX_CTRL_IOP_BIT = 0;
  localparam logic SDTX_CTRL_IOP_RST = 1'b1;

  // status register fields above the packed mode word
  localparam int SDTX_ST_FRST_BIT = 10;
  localparam int SDTX_ST_JTAG_BIT = 11;

  // bus response codes
  localparam logic [1:0] SDTX_RESP_OKAY = 2'h0;
  localparam logic [1:0] SDTX_RESP_SLVERR = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // operating modes and timing sources
  typedef enum logic [1:0] {
    SDTX_OP_SMPTE = 2'b00,
    SDTX_OP_ASI = 2'b01,
    SDTX_OP_THRU = 2'b10
  } sdtx_op_e;

  typedef enum logic [1:0] {
    SDTX_TIM_HVF = 2'b00,
    SDTX_TIM_SYNC = 2'b01,
    SDTX_TIM_TRS = 2'b10
  } sdtx_tim_e;

  // use of the lower ten-bit data bus
  typedef enum logic [1:0] {
    SDTX_LB_UNUSED = 2'b00,
    SDTX_LB_CHROMA = 2'b01,
    SDTX_LB_DATA = 2'b10
  } sdtx_lbus_e;

  // register select from address decode
  typedef enum logic [1:0] {
    SDTX_REG_CTRL = 2'b00,
    SDTX_REG_STAT = 2'b01,
    SDTX_REG_PINS = 2'b10,
    SDTX_REG_NONE = 2'b11
  } sdtx_reg_e;

  typedef enum logic {
    SDTX_WR_COLLECT = 1'b0,
    SDTX_WR_RESP = 1'b1
  } sdtx_wr_e;

  typedef enum logic {
    SDTX_RD_IDLE = 1'b0,
    SDTX_RD_DATA = 1'b1
  } sdtx_rd_e;

  ////////////////////////////////////////////////////////////////////////////
  // static control pins, msb first
  typedef struct packed {
    logic jtag_host;
    logic timing_style;
    logic embedded_timing;
    logic bus_width;
    logic asi_mode;
    logic video_proc;
    logic proc_feature;
    logic rst_n;
  } sdtx_pins_s;

  // decoded operating mode, msb first
  typedef struct packed {
    sdtx_op_e op;
    sdtx_tim_e tim;
    sdtx_lbus_e lbus;
    logic bus_20bit;
    logic scramble_en;
    logic ioproc_en;
    logic asi_align_en;
  } sdtx_mode_s;

  localparam sdtx_mode_s SDTX_MODE_RST = '{
    op: SDTX_OP_THRU,
    tim: SDTX_TIM_HVF,
    lbus: SDTX_LB_UNUSED,
    bus_20bit: 1'b0,
    scramble_en: 1'b0,
    ioproc_en: 1'b0,
    asi_align_en: 1'b0
  };

endpackage

// [rtl/sdtx_mode_dec.sv]
`timescale 1ns/1ps
module sdtx_mode_dec
  import sdtx_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic func_rst_i,
  input wire logic host_iop_en_i,
  input wire sdtx_pins_s pins_i,
  output sdtx_mode_s mode_o
);

  sdtx_mode_s mode_q;

  ////////////////////////////////////////////////////////////////////////////
  // pin levels to operating mode
  function automatic sdtx_mode_s decode(input sdtx_pins_s p,
                                        input logic host_en);
    sdtx_mode_s m;
    m = SDTX_MODE_RST;
    // processing select wins over asi select
    if (p.video_proc) begin
      m.op = SDTX_OP_SMPTE;
    end else if (p.asi_mode) begin
      m.op = SDTX_OP_ASI;
    end else begin
      m.op = SDTX_OP_THRU;
    end
    // embedded timing overrides the style select
    if (p.embedded_timing) begin
      m.tim = SDTX_TIM_TRS;
    end else if (p.timing_style) begin
      m.tim = SDTX_TIM_SYNC;
    end else begin
      m.tim = SDTX_TIM_HVF;
    end
    m.bus_20bit = p.bus_width;
    m.scramble_en = p.video_proc;
    // feature enable only counts in smpte mode
    m.ioproc_en = p.video_proc & p.proc_feature & host_en;
    m.asi_align_en = ~p.video_proc & p.asi_mode;
    // lower bus use in 20-bit mode
    if (!p.bus_width) begin
      m.lbus = SDTX_LB_UNUSED;
    end else if (m.op == SDTX_OP_SMPTE) begin
      m.lbus = SDTX_LB_CHROMA;
    end else if (m.op == SDTX_OP_THRU) begin
      m.lbus = SDTX_LB_DATA;
    end else begin
      m.lbus = SDTX_LB_UNUSED;
    end
    return m;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // mode held in flops so changes land on clock boundaries
  always_ff @(posedge clk_sys_i) begin
    if (func_rst_i) begin
      mode_q <= SDTX_MODE_RST;
    end else begin
      mode_q <= decode(pins_i, host_iop_en_i);
    end
  end

  assign mode_o = mode_q;

endmodule

// [rtl/sdtx_mode_ctrl.sv]
// Functional notes
// - test results leave on the dedicated tdo pin while host select is low
// - both timing selects low: timing from separate h, v, f inputs
// - style select high, embedded low: timing from hsync, vsync, de
// - embedded timing select high: timing from embedded trs words
// - bus width select picks 10-bit or 20-bit parallel input
// - asi high with processing low: asi alignment, processing, send
// - asi and processing both low: data-through, no encoding
// - processing low: no scrambling, no i/o processing features
// - processing high: scrambling plus i/o processing
// - feature enable gates i/o processing, only in smpte mode
// - normal mode reset low: blocks to default, all pins high impedance
// - reset back high in normal mode: operation resumes
// - jtag mode reset low: defaults and test sequence reset
// - 20-bit smpte mode: lower ten-bit bus carries chroma
`timescale 1ns/1ps
module sdtx_mode_ctrl
  import sdtx_pkg::*;
#(
  parameter int AXI_AW = 4,
  parameter int DW = 10
) (
  input wire logic clk_sys_i,
  input wire logic srst_i,
  // axi4-lite slave
  input wire logic [AXI_AW-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [AXI_AW-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // static control pins
  input wire logic device_rst_n_i,
  input wire logic jtag_host_select_i,
  input wire logic timing_style_select_i,
  input wire logic embedded_timing_select_i,
  input wire logic bus_width_select_i,
  input wire logic asi_mode_select_i,
  input wire logic video_processing_select_i,
  input wire logic processing_feature_enable_i,
  // test data from the scan logic
  input wire logic test_result_i,
  output logic tdo_o,
  output logic tdo_oe_o,
  // reset and pad control
  output logic func_rst_o,
  output logic jtag_seq_rst_o,
  output logic io_oe_o,
  // decoded mode and lower bus
  output sdtx_mode_s mode_o,
  input wire logic [DW-1:0] din_low_i,
  output logic [DW-1:0] chroma_o,
  output logic [DW-1:0] thru_low_o
);

  ////////////////////////////////////////////////////////////////////////////
  // address decode shared by read and write paths
  function automatic sdtx_reg_e reg_sel(input logic [AXI_AW-1:0] a);
    if (a == AXI_AW'(SDTX_CTRL_OFS)) begin
      return SDTX_REG_CTRL;
    end else if (a == AXI_AW'(SDTX_STAT_OFS)) begin
      return SDTX_REG_STAT;
    end else if (a == AXI_AW'(SDTX_PINS_OFS)) begin
      return SDTX_REG_PINS;
    end else begin
      return SDTX_REG_NONE;
    end
  endfunction

  sdtx_pins_s pins_w;
  sdtx_mode_s mode_w;
  logic func_rst_q;
  logic jtag_mode_q;
  logic jtag_seq_rst_q;
  logic io_oe_q;
  logic io_oe_d;
  logic tdo_q;
  logic tdo_oe_q;
  logic tdo_oe_d;
  logic ctrl_iop_q;
  logic [DW-1:0] chroma_q;
  logic [DW-1:0] thru_q;
  sdtx_wr_e wr_st_q;
  logic aw_have_q;
  logic w_have_q;
  logic [AXI_AW-1:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic [1:0] bresp_q;
  logic aw_fire;
  logic w_fire;
  logic wr_do;
  logic [AXI_AW-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  sdtx_reg_e wr_sel;
  sdtx_rd_e rd_st_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic ar_fire;
  sdtx_reg_e rd_sel;

  ////////////////////////////////////////////////////////////////////////////
  // pin bundle for decode and readback
  assign pins_w = '{
    jtag_host: jtag_host_select_i,
    timing_style: timing_style_select_i,
    embedded_timing: embedded_timing_select_i,
    bus_width: bus_width_select_i,
    asi_mode: asi_mode_select_i,
    video_proc: video_processing_select_i,
    proc_feature: processing_feature_enable_i,
    rst_n: device_rst_n_i
  };

  ////////////////////////////////////////////////////////////////////////////
  // reset pin handling, normal and test modes
  always_ff @(posedge clk_sys_i) begin
    func_rst_q <= srst_i | ~device_rst_n_i;
  end

  // test sequence reset only while the host port is in test mode
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      jtag_mode_q <= 1'b0;
      jtag_seq_rst_q <= 1'b0;
    end else begin
      jtag_mode_q <= jtag_host_select_i;
      jtag_seq_rst_q <= jtag_host_select_i & ~device_rst_n_i;
    end
  end

  // pads float while reset is low in normal mode
  assign io_oe_d = ~srst_i & (device_rst_n_i | jtag_host_select_i);

  always_ff @(posedge clk_sys_i) begin
    io_oe_q <= io_oe_d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // dedicated test data output
  assign tdo_oe_d = io_oe_d & ~jtag_host_select_i;

  always_ff @(posedge clk_sys_i) begin
    tdo_oe_q <= tdo_oe_d;
    tdo_q <= tdo_oe_d & test_result_i;
  end

  ////////////////////////////////////////////////////////////////////////////
  // mode decode and registering
  sdtx_mode_dec u_dec (
    .clk_sys_i(clk_sys_i),
    .func_rst_i(func_rst_q | srst_i),
    .host_iop_en_i(ctrl_iop_q),
    .pins_i(pins_w),
    .mode_o(mode_w)
  );

  ////////////////////////////////////////////////////////////////////////////
  // lower bus steering in 20-bit mode
  always_ff @(posedge clk_sys_i) begin
    if (func_rst_q | srst_i) begin
      chroma_q <= '0;
      thru_q <= '0;
    end else begin
      if (mode_w.lbus == SDTX_LB_CHROMA) begin
        chroma_q <= din_low_i;
      end else begin
        chroma_q <= '0;
      end
      if (mode_w.lbus == SDTX_LB_DATA) begin
        thru_q <= din_low_i;
      end else begin
        thru_q <= '0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // write channel: address and data may arrive in either order
  assign s_axi_awready_o = (wr_st_q == SDTX_WR_COLLECT) & ~aw_have_q;
  assign s_axi_wready_o = (wr_st_q == SDTX_WR_COLLECT) & ~w_have_q;
  assign aw_fire = s_axi_awvalid_i & s_axi_awready_o;
  assign w_fire = s_axi_wvalid_i & s_axi_wready_o;
  assign wr_do = (wr_st_q == SDTX_WR_COLLECT) & (aw_have_q | aw_fire) &
                 (w_have_q | w_fire);
  assign wr_addr = aw_have_q ? aw_addr_q : s_axi_awaddr_i;
  assign wr_data = w_have_q ? w_data_q : s_axi_wdata_i;
  assign wr_strb = w_have_q ? w_strb_q : s_axi_wstrb_i;
  assign wr_sel = reg_sel(wr_addr);

  // holding flags for an early address or data beat
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_addr_q <= '0;
      w_data_q <= '0;
      w_strb_q <= '0;
    end else if (wr_do) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
    end else begin
      if (aw_fire) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr_i;
      end
      if (w_fire) begin
        w_have_q <= 1'b1;
        w_data_q <= s_axi_wdata_i;
        w_strb_q <= s_axi_wstrb_i;
      end
    end
  end

  // write response state
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      wr_st_q <= SDTX_WR_COLLECT;
      bresp_q <= SDTX_RESP_OKAY;
    end else begin
      case (wr_st_q)
        SDTX_WR_COLLECT: begin
          if (wr_do) begin
            wr_st_q <= SDTX_WR_RESP;
            if (wr_sel == SDTX_REG_CTRL) begin
              bresp_q <= SDTX_RESP_OKAY;
            end else begin
              bresp_q <= SDTX_RESP_SLVERR;
            end
          end
        end
        SDTX_WR_RESP: begin
          if (s_axi_bready_i) begin
            wr_st_q <= SDTX_WR_COLLECT;
          end
        end
        default: begin
          wr_st_q <= SDTX_WR_COLLECT;
        end
      endcase
    end
  end

  assign s_axi_bvalid_o = (wr_st_q == SDTX_WR_RESP);
  assign s_axi_bresp_o = bresp_q;

  ////////////////////////////////////////////////////////////////////////////
  // host gate for the i/o processing features, back to default on reset
  always_ff @(posedge clk_sys_i) begin
    if (srst_i | func_rst_q) begin
      ctrl_iop_q <= SDTX_CTRL_IOP_RST;
    end else if (wr_do & (wr_sel == SDTX_REG_CTRL) & wr_strb[0]) begin
      ctrl_iop_q <= wr_data[SDTX_CTRL_IOP_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read channel
  assign s_axi_arready_o = (rd_st_q == SDTX_RD_IDLE);
  assign ar_fire = s_axi_arvalid_i & s_axi_arready_o;
  assign rd_sel = reg_sel(s_axi_araddr_i);

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      rd_st_q <= SDTX_RD_IDLE;
      rdata_q <= '0;
      rresp_q <= SDTX_RESP_OKAY;
    end else begin
      case (rd_st_q)
        SDTX_RD_IDLE: begin
          if (ar_fire) begin
            rd_st_q <= SDTX_RD_DATA;
            rresp_q <= SDTX_RESP_OKAY;
            rdata_q <= '0;
            if (rd_sel == SDTX_REG_CTRL) begin
              rdata_q[SDTX_CTRL_IOP_BIT] <= ctrl_iop_q;
            end else if (rd_sel == SDTX_REG_STAT) begin
              rdata_q[9:0] <= mode_w;
              rdata_q[SDTX_ST_FRST_BIT] <= func_rst_q;
              rdata_q[SDTX_ST_JTAG_BIT] <= jtag_mode_q;
            end else if (rd_sel == SDTX_REG_PINS) begin
              rdata_q[7:0] <= pins_w;
            end else begin
              rresp_q <= SDTX_RESP_SLVERR;
            end
          end
        end
        SDTX_RD_DATA: begin
          if (s_axi_rready_i) begin
            rd_st_q <= SDTX_RD_IDLE;
          end
        end
        default: begin
          rd_st_q <= SDTX_RD_IDLE;
        end
      endcase
    end
  end

  assign s_axi_rvalid_o = (rd_st_q == SDTX_RD_DATA);
  assign s_axi_rdata_o = rdata_q;
  assign s_axi_rresp_o = rresp_q;

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign func_rst_o = func_rst_q;
  assign jtag_seq_rst_o = jtag_seq_rst_q;
  assign io_oe_o = io_oe_q;
  assign tdo_o = tdo_q;
  assign tdo_oe_o = tdo_oe_q;
  assign mode_o = mode_w;
  assign chroma_o = chroma_q;
  assign thru_low_o = thru_q;

endmodule

// [verification/sdtx_board_ctl.sv]
`timescale 1ns/1ps
module sdtx_board_ctl
  import sdtx_pkg::*;
(
  input wire logic clk_sys_i,
  input wire sdtx_pins_s set_i,
  output sdtx_pins_s pins_o
);
  // board logic moves its static settings onto the pins at a clock edge
  always_ff @(posedge clk_sys_i) begin
    pins_o <= set_i;
  end
endmodule

// [verification/sdtx_mode_ctrl_checker.sv]
`timescale 1ns/1ps
module sdtx_mode_ctrl_checker
  import sdtx_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic srst_i,
  input wire logic device_rst_n_i,
  input wire logic jtag_host_select_i,
  input wire logic timing_style_select_i,
  input wire logic embedded_timing_select_i,
  input wire logic bus_width_select_i,
  input wire logic asi_mode_select_i,
  input wire logic video_processing_select_i,
  input wire logic processing_feature_enable_i,
  input wire logic test_result_i,
  input wire logic tdo_o,
  input wire logic tdo_oe_o,
  input wire logic func_rst_o,
  input wire logic jtag_seq_rst_o,
  input wire logic io_oe_o,
  input wire sdtx_mode_s mode_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (srst_i);

  // decoder was free to load the pins at this edge
  logic upd;
  assign upd = !func_rst_o && !srst_i;

  ////////////////////////////////////////////////////////////////////////////
  AST_TDO_OE: assert property (
    $past(jtag_host_select_i) |-> !tdo_oe_o)
    else $error("tdo driven in test mode");
  AST_TDO_DATA: assert property (
    tdo_oe_o |-> tdo_o == $past(test_result_i))
    else $error("tdo does not carry test data");
  AST_TIM: assert property ($past(upd) |->
    mode_o.tim == ($past(embedded_timing_select_i) ? SDTX_TIM_TRS :
    $past(timing_style_select_i) ? SDTX_TIM_SYNC : SDTX_TIM_HVF))
    else $error("wrong timing source");
  AST_WIDTH: assert property ($past(upd) |-> mode_o.bus_20bit ==
    $past(bus_width_select_i)) else $error("wrong bus width");
  AST_ASI: assert property ($past(upd && asi_mode_select_i &&
    !video_processing_select_i) |-> mode_o.op == SDTX_OP_ASI &&
    mode_o.asi_align_en) else $error("asi mode not entered");
  AST_THRU: assert property ($past(upd && !asi_mode_select_i &&
    !video_processing_select_i) |-> mode_o.op == SDTX_OP_THRU)
    else $error("data-through not entered");
  AST_NO_SCR: assert property (
    $past(upd && !video_processing_select_i) |->
    !mode_o.scramble_en && !mode_o.ioproc_en)
    else $error("scrambling while processing off");
  AST_SMPTE: assert property (
    $past(upd && video_processing_select_i) |->
    mode_o.op == SDTX_OP_SMPTE && mode_o.scramble_en)
    else $error("smpte mode not entered");
  AST_IOP: assert property ($past(upd) && mode_o.ioproc_en |->
    $past(processing_feature_enable_i && video_processing_select_i))
    else $error("i/o processing without enable");
  AST_RST_NORM: assert property ($past(!device_rst_n_i &&
    !jtag_host_select_i) |-> func_rst_o && !io_oe_o && !tdo_oe_o)
    else $error("normal reset not applied");
  AST_MODE_RST: assert property (
    func_rst_o |=> mode_o == SDTX_MODE_RST)
    else $error("mode not default under reset");
  AST_RESUME: assert property (
    $past(device_rst_n_i && !srst_i) |->
    !func_rst_o && !jtag_seq_rst_o && io_oe_o) else $error("no resume");
  // bench reset clears the test sequence flop, so leave that edge out
  AST_RST_JTAG: assert property ($past(!device_rst_n_i &&
    jtag_host_select_i && !srst_i) |->
    func_rst_o && jtag_seq_rst_o && io_oe_o)
    else $error("test reset not applied");
  AST_CHROMA: assert property ($past(upd && bus_width_select_i &&
    video_processing_select_i) |-> mode_o.lbus == SDTX_LB_CHROMA)
    else $error("lower bus not chroma");
endmodule

bind sdtx_mode_ctrl sdtx_mode_ctrl_checker i_sdtx_mode_ctrl_checker (.*);

// [verification/sdtx_mode_ctrl_tb.sv]
`timescale 1ns/1ps
module sdtx_mode_ctrl_tb;
  import sdtx_pkg::*;
  logic clk_sys_i = 1'h0;
  logic srst_i = 1'h1;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0;
  logic rready = 1'h0, test_result = 1'h0;
  logic [31:0] wdata = 32'h0, rdata;
  logic [9:0] din = 10'h0, chroma, thru;
  logic awready, wready, bvalid, arready, rvalid, tdo, tdo_oe;
  logic frst, jrst, io_oe;
  logic [1:0] bresp, rresp;
  sdtx_pins_s set = 8'h01;
  sdtx_pins_s pins;
  sdtx_mode_s mode, em;
  int error_cnt = 0, n_compared = 0, seed = 42718, cyc = 0;

  sdtx_board_ctl i_sdtx_board_ctl (.clk_sys_i(clk_sys_i), .set_i(set),
    .pins_o(pins));
  sdtx_mode_ctrl i_sdtx_mode_ctrl (.clk_sys_i(clk_sys_i), .srst_i(srst_i),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
    .s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hf),
    .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
    .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
    .device_rst_n_i(pins.rst_n), .jtag_host_select_i(pins.jtag_host),
    .timing_style_select_i(pins.timing_style),
    .embedded_timing_select_i(pins.embedded_timing),
    .bus_width_select_i(pins.bus_width), .asi_mode_select_i(pins.asi_mode),
    .video_processing_select_i(pins.video_proc),
    .processing_feature_enable_i(pins.proc_feature),
    .test_result_i(test_result), .tdo_o(tdo), .tdo_oe_o(tdo_oe),
    .func_rst_o(frst), .jtag_seq_rst_o(jrst), .io_oe_o(io_oe), .mode_o(mode),
    .din_low_i(din), .chroma_o(chroma), .thru_low_o(thru));

  ////////////////////////////////////////////////////////////////////////////
  // clock and hang watchdog
  initial begin
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      $display("ERROR %0t: timeout", $time);
      finish_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // comparison, bus cycles and settling
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic axw(input logic [3:0] a, input logic [31:0] d,
                     input logic [1:0] er);
    // start on an edge so a previous call's release is not overwritten
    @(posedge clk_sys_i);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge clk_sys_i);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end while (!bvalid);
    bready <= 1'h0;
    chk(bresp, er);
  endtask

  task automatic axr(input logic [3:0] a, input logic [31:0] ed,
                     input logic [1:0] er);
    // start on an edge so a previous call's release is not overwritten
    @(posedge clk_sys_i);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge clk_sys_i);
      if (arready) arvalid <= 1'h0;
    end while (!rvalid);
    rready <= 1'h0;
    chk(rdata, ed);
    chk(rresp, er);
  endtask

  task automatic settle(input sdtx_pins_s p);
    set <= p;
    repeat (4) @(posedge clk_sys_i);
    #1;
  endtask

  // lower bus follows the input one cycle late when its use is selected
  task automatic lowbus(input sdtx_mode_s m);
    logic [9:0] v;
    v = 10'($random(seed));
    din <= v;
    @(posedge clk_sys_i);
    #1;
    chk(chroma, m.lbus == SDTX_LB_CHROMA ? v : 10'h0);
    chk(thru, m.lbus == SDTX_LB_DATA ? v : 10'h0);
  endtask

  // reference decode of the mode pins
  function automatic sdtx_mode_s dec(input sdtx_pins_s p, input logic hi);
    sdtx_mode_s m;
    m = SDTX_MODE_RST;
    m.bus_20bit = p.bus_width;
    m.tim = p.embedded_timing ? SDTX_TIM_TRS :
            p.timing_style ? SDTX_TIM_SYNC : SDTX_TIM_HVF;
    if (p.video_proc) begin
      m.op = SDTX_OP_SMPTE;
      m.scramble_en = 1'h1;
      m.ioproc_en = p.proc_feature & hi;
      if (p.bus_width) m.lbus = SDTX_LB_CHROMA;
    end else if (p.asi_mode) begin
      m.op = SDTX_OP_ASI;
      m.asi_align_en = 1'h1;
    end else if (p.bus_width) begin
      m.lbus = SDTX_LB_DATA;
    end
    return m;
  endfunction

  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    sdtx_pins_s p;
    repeat (6) @(posedge clk_sys_i);
    srst_i <= 1'h0;
    // every combination of the six mode pins in host mode
    for (int i = 0; i < 64; i++) begin
      p = {1'h0, 6'(i), 1'h1};
      settle(p);
      em = dec(p, 1'h1);
      chk(mode, em);
      lowbus(em);
      axr(SDTX_STAT_OFS, {22'h0, em}, SDTX_RESP_OKAY);
      axr(SDTX_PINS_OFS, {24'h0, p}, SDTX_RESP_OKAY);
    end
    $display("test pin decode done");
    // host side gate of i/o processing, refused accesses
    settle(8'h07);
    axw(SDTX_CTRL_OFS, 32'h0, SDTX_RESP_OKAY);
    settle(8'h07);
    chk(mode, dec(8'h07, 1'h0));
    axr(SDTX_CTRL_OFS, 32'h0, SDTX_RESP_OKAY);
    axw(SDTX_STAT_OFS, 32'h0, SDTX_RESP_SLVERR);
    axr(4'hc, 32'h0, SDTX_RESP_SLVERR);
    $display("test host gate done");
    // reset pin in normal mode, then resume
    settle(8'h06);
    chk({frst, io_oe, tdo_oe}, 3'h4);
    chk(mode, SDTX_MODE_RST);
    settle(8'h07);
    chk({frst, io_oe, tdo_oe}, 3'h3);
    chk(mode, dec(8'h07, 1'h1));
    axr(SDTX_CTRL_OFS, 32'h1, SDTX_RESP_OKAY);
    $display("test normal reset done");
    // test data leaves on the dedicated pin in host mode
    repeat (8) begin
      test_result <= 1'($random(seed));
      @(posedge clk_sys_i);
      #1;
      chk(tdo, test_result);
    end
    $display("test tdo done");
    // reset pin in test mode
    settle(8'h87);
    chk({frst, jrst, io_oe, tdo_oe}, 4'h2);
    settle(8'h86);
    chk({frst, jrst, io_oe, tdo_oe}, 4'he);
    chk(mode, SDTX_MODE_RST);
    settle(8'h87);
    chk({frst, jrst, io_oe, tdo_oe}, 4'h2);
    chk(mode, dec(8'h87, 1'h1));
    $display("test jtag reset done");
    finish_test();
  end
endmodule
